// file: hdl/bbldec_decoder.sv
`timescale 1ns/100ps
// Operation
// RULE_01: Every instruction is one 14-bit word: opcode plus operand fields.
// RULE_02: Each word falls into exactly one of three instruction categories.
// RULE_03: Byte-oriented words select their data register by the file-address field.
// RULE_04: File-address field is seven bits, reaching registers 0x00 to 0x7f.
// RULE_05: Destination bit 0 writes working register, 1 writes the file register.
// RULE_06: Bit-oriented words pick one of eight bits via bit-select field.
// RULE_07: Literal words carry an 8-bit constant or an 11-bit target.
// RULE_08: One instruction cycle lasts four oscillator periods.
// RULE_09: True test or changed counter adds a second, no-operation cycle.
// RULE_10: File-register words read first, modify, then store, even write-only ones.
// RULE_11: Clearing a port register reads the port first, may clear change mismatch.
// RULE_12: Don't-care opcode bits are ignored; generators should fill them with zero.
// RULE_13: Top two bits choose byte, bit, call/goto, or literal category.
`include "bbldec_regs.svh"

module bbldec_decoder #(
    parameter int PHASES = `BBLDEC_PHASES
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // Instruction word from program memory
    input  wire logic [13:0]             instr_word,
    input  wire logic                    instr_valid,
    // Execution feedback
    input  wire logic                    test_true,
    input  wire logic                    port_one_register_sel,
    // Decoded instruction
    output logic                         dec_valid,
    output bbldec_pkg::bbldec_fields_t   dec_fields,
    // Timing strobes
    output logic [1:0]                   phase,
    output logic                         file_rd_stb,
    output logic                         file_wr_stb,
    output logic                         no_operation_cycle,
    output logic                         cycle_end,
    output logic                         port_clear_read
);
    import bbldec_pkg::*;

    bbldec_state_s_t s_q;
    bbldec_state_s_t s_d;
    bbldec_fields_t  f;

    localparam logic [1:0] LAST_PHASE = 2'(PHASES - 1);

    // Word layout, most significant bit first:
    //   [13:12] class: 00 byte, 01 bit, 10 call or goto, 11 literal
    //   [11:8]  operation nibble of a byte op
    //   [11:10] operation of a bit op, with the bit select in [9:7]
    //   [7]     destination of a byte op: 0 working register, 1 file
    //   [6:0]   file address, 128 locations
    //   [7:0]   short literal; [10:0] long jump target
    // Every field is cut from every word whatever the class; only d and the
    // file address are then forced for some words. The class and control bits
    // say which fields mean anything, so only those two fields need muxes.
    // A consumer must never act on a field its class does not use.

    ////////////////////////////////////////////////////////////////////////
    // Field extraction, purely combinational
    always_comb begin
        f = '0;
        // RULE_01 whole word
        // RULE_13 class select
        // RULE_02 one category
        f.cls       = bbldec_class_t'(instr_word[`BBLDEC_CLASS_HI:`BBLDEC_CLASS_LO]);
        // RULE_03 file address
        // RULE_04 seven bit range
        f.file_addr = instr_word[`BBLDEC_FILE_HI:0];
        // RULE_05 destination select
        f.dest_file = instr_word[`BBLDEC_DEST_BIT];
        // RULE_06 bit select
        f.bit_sel   = instr_word[`BBLDEC_BIT_HI:`BBLDEC_BIT_LO];
        // RULE_07 literal fields
        f.lit8      = instr_word[`BBLDEC_LIT8_HI:0];
        f.lit11     = instr_word[`BBLDEC_LIT11_HI:0];
        // Control bits per class; d is forced in the control group and in bit and literal words, not in call or goto
        case (f.cls)
            BBLDEC_CLS_BYTE: begin
                // Opcode nibble 0000 with d=0 holds the control group
                if (instr_word[11:8] == 4'h0 && !instr_word[7]) begin
                    f.dest_file = 1'b0;
                    // Return group changes the counter
                    f.pc_change = (instr_word[6:0] == 7'h08) || (instr_word[6:0] == 7'h09);
                end else if (instr_word[11:8] == 4'h1 && !instr_word[7]) begin
                    // Clear working register: address bits are don't care
                    // RULE_12 ignore dont care
                    f.file_addr = 7'h00;
                end else begin
                    // RULE_10 read before write
                    f.file_read  = 1'b1;
                    f.file_write = f.dest_file;
                    // Clear still reads first; a port read has side effects
                    f.clear_reg  = (instr_word[11:8] == 4'h1);
                    // Decrement or increment, then skip on zero
                    f.cond_test  = (instr_word[11:8] == 4'hb) || (instr_word[11:8] == 4'hf);
                end
            end
            BBLDEC_CLS_BIT: begin
                // Tests only read; set and clear write back
                f.dest_file  = 1'b1;
                f.file_read  = 1'b1;
                f.file_write = !instr_word[11];
                f.cond_test  = instr_word[11];
            end
            BBLDEC_CLS_JUMP: begin
                // Both call and goto load the counter
                f.pc_change = 1'b1;
            end
            default: begin
                f.dest_file = 1'b0;
                // Return with literal; the x bits are don't care
                // RULE_12 ignore dont care
                f.pc_change = (instr_word[11:10] == 2'b01);
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction cycle sequencer
    // Cycle walk, one clock per oscillator period:
    //   edge at phase 3: word taken, fields registered
    //   phase 0: fields and valid stand for the whole cycle
    //   phase 1: file read strobe and port read marker
    //   phase 3: store strobe; test result sampled at its edge
    //   next phase 0: cycle end; a taken branch opens a no-op cycle
    // The phase counter runs free, so a word offered off phase 3 simply
    // waits; this keeps fetch timing fixed at the cost of latency.
    always_comb begin
        s_d                 = s_q;
        // Strobes default low; each lives one clock
        s_d.rd_stb          = 1'b0;
        s_d.wr_stb          = 1'b0;
        s_d.cycle_end       = 1'b0;
        s_d.port_clear_read = 1'b0;
        // RULE_08 four phases
        s_d.phase = (s_q.phase == LAST_PHASE) ? 2'h0 : s_q.phase + 2'h1;
        case (s_q.state)
            BBLDEC_ST_FETCH: begin
                s_d.valid     = 1'b0;
                s_d.nop_cycle = 1'b0;
                // Idle until a word stands at phase 3
                if (s_q.phase == LAST_PHASE && instr_valid) begin
                    s_d.fields = f;
                    s_d.valid  = 1'b1;
                    s_d.state  = BBLDEC_ST_EXEC;
                end
            end
            BBLDEC_ST_EXEC: begin
                // RULE_10 read phase
                if (s_q.phase == 2'h0 && s_q.fields.file_read) begin
                    s_d.rd_stb = 1'b1;
                    // RULE_11 port read on clear
                    s_d.port_clear_read = s_q.fields.clear_reg && port_one_register_sel;
                end
                // Store lands in the last phase, after modify
                if (s_q.phase == 2'h2 && s_q.fields.file_write) begin
                    s_d.wr_stb = 1'b1;
                end
                if (s_q.phase == LAST_PHASE) begin
                    s_d.cycle_end = 1'b1;
                    s_d.valid     = 1'b0;
                    // Test result must be settled by this edge; a late one
                    // is missed, since nothing here holds it
                    // RULE_09 extra no-op cycle
                    if (s_q.fields.pc_change || (s_q.fields.cond_test && test_true)) begin
                        s_d.state     = BBLDEC_ST_FLUSH;
                        s_d.nop_cycle = 1'b1;
                    end else if (instr_valid) begin
                        // Back-to-back issue without an idle cycle
                        s_d.fields = f;
                        s_d.valid  = 1'b1;
                    end else begin
                        s_d.state = BBLDEC_ST_FETCH;
                    end
                end
            end
            BBLDEC_ST_FLUSH: begin
                // Prefetched word is discarded during the no-op cycle
                // Fetch resumes a whole cycle later; a bypass would save
                // four clocks but doubles the paths into the field flops
                if (s_q.phase == LAST_PHASE) begin
                    s_d.cycle_end = 1'b1;
                    s_d.nop_cycle = 1'b0;
                    s_d.state     = BBLDEC_ST_FETCH;
                end
            end
            default: begin
                // Unused state code recovers to idle
                s_d.state = BBLDEC_ST_FETCH;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    // Async reset clears every flop; phase restarts at its reset value,
    // so the first word is taken on the fourth edge after release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q       <= '0;
            s_q.phase <= `BBLDEC_PHASE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state flops
    assign dec_valid          = s_q.valid;
    assign dec_fields         = s_q.fields;
    // Free-running phase count
    assign phase              = s_q.phase;
    // One-clock file strobes
    assign file_rd_stb        = s_q.rd_stb;
    assign file_wr_stb        = s_q.wr_stb;
    // Cycle markers
    assign no_operation_cycle = s_q.nop_cycle;
    assign cycle_end          = s_q.cycle_end;
    // Port side effect marker
    assign port_clear_read    = s_q.port_clear_read;

endmodule // bbldec_decoder

// file: shared/bbldec_regs.svh
`ifndef BBLDEC_REGS_SVH
`define BBLDEC_REGS_SVH
// Instruction word layout
`define BBLDEC_WORD_W      14
`define BBLDEC_CLASS_HI    13
`define BBLDEC_CLASS_LO    12
`define BBLDEC_FILE_HI     6
`define BBLDEC_DEST_BIT    7
`define BBLDEC_BIT_HI      9
`define BBLDEC_BIT_LO      7
`define BBLDEC_LIT8_HI     7
`define BBLDEC_LIT11_HI    10
// Oscillator periods per instruction cycle
`define BBLDEC_PHASES      4
// Reset value of the phase counter
`define BBLDEC_PHASE_RST   2'h0
`endif

// file: shared/bbldec_pkg.sv
package bbldec_pkg;
    typedef enum logic [1:0] {
        BBLDEC_CLS_BYTE,
        BBLDEC_CLS_BIT,
        BBLDEC_CLS_JUMP,
        BBLDEC_CLS_LIT
    } bbldec_class_t;

    typedef enum logic [1:0] {
        BBLDEC_ST_FETCH,
        BBLDEC_ST_EXEC,
        BBLDEC_ST_FLUSH
    } bbldec_state_t;

    // Decoded fields of one instruction
    typedef struct packed {
        bbldec_class_t cls;
        logic [6:0]    file_addr;
        logic          dest_file;
        logic [2:0]    bit_sel;
        logic [7:0]    lit8;
        logic [10:0]   lit11;
        logic          file_read;
        logic          file_write;
        logic          clear_reg;
        logic          pc_change;
        logic          cond_test;
    } bbldec_fields_t;

    // Whole module state
    typedef struct packed {
        bbldec_state_t  state;
        logic [1:0]     phase;
        bbldec_fields_t fields;
        logic           valid;
        logic           rd_stb;
        logic           wr_stb;
        logic           nop_cycle;
        logic           cycle_end;
        logic           port_clear_read;
    } bbldec_state_s_t;
endpackage

// file: sim/bbldec_properties.sv
`timescale 1ns/100ps
module bbldec_properties (
    // Clock and reset
    input logic                       clk,
    input logic                       reset_n,
    // Word and decoder outputs
    input logic [13:0]                instr_word,
    input logic                       dec_valid,
    input bbldec_pkg::bbldec_fields_t dec_fields,
    input logic [1:0]                 phase,
    input logic                       file_rd_stb,
    input logic                       file_wr_stb,
    input logic                       no_operation_cycle,
    input logic                       cycle_end,
    input logic                       port_clear_read
);
    import bbldec_pkg::*;
    logic [13:0] word_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Word seen one edge back, for field checks
    always_ff @(posedge clk) word_q <= instr_word;
    // Inserted idle cycle: four clocks, then gone
    sequence nop_run;
        no_operation_cycle [*4] ##1 !no_operation_cycle;
    endsequence
    ////////////////////
    phase_step_a: assert property ($past(reset_n) |-> phase == $past(phase) + 2'h1)
        else $error("phase did not advance");
    cycle_end_a: assert property (cycle_end |-> phase == 2'h0)
        else $error("cycle end off its slot");
    read_slot_a: assert property (file_rd_stb |-> phase == 2'h1)
        else $error("file read off its slot");
    write_order_a: assert property (file_wr_stb |-> phase == 2'h3 && $past(file_rd_stb, 2))
        else $error("store without prior read");
    port_read_a: assert property (port_clear_read |-> file_rd_stb && dec_fields.clear_reg)
        else $error("port read without clear");
    nop_len_a: assert property ($rose(no_operation_cycle) |-> nop_run)
        else $error("idle cycle length wrong");
    jump_nop_a: assert property (dec_valid && dec_fields.pc_change && phase == 2'h3 |=> no_operation_cycle)
        else $error("no idle cycle after jump");
    nop_quiet_a: assert property (no_operation_cycle |-> !dec_valid && !file_rd_stb)
        else $error("activity in idle cycle");
    field_take_a: assert property ($rose(dec_valid) |-> dec_fields.cls == word_q[13:12])
        else $error("class not from top bits");
endmodule // bbldec_properties

// file: sim/bbldec_progmem.sv
`timescale 1ns/100ps
module bbldec_progmem (
    // Clock, reset and decoder timing
    input logic        clk,
    input logic        reset_n,
    input logic [1:0]  phase,
    input logic        no_operation_cycle,
    input logic        stall,
    // Decoder discards the word offered at a branch; offer it again
    input logic        drop,
    // Word toward the decoder
    output logic [13:0] instr_word,
    output logic        instr_valid
);
    logic [13:0] mem [64];
    logic [13:0] last_q;
    int          idx;
    // Stalled memory shows junk, not the old word
    assign instr_valid = !stall && idx < 64;
    assign instr_word = instr_valid ? mem[idx] : ~last_q;
    // Advance on each word the decoder takes
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            idx <= 0;
            last_q <= 14'h0000;
        end else if (phase == 2'h3 && instr_valid && !no_operation_cycle && !drop) begin
            idx <= idx + 1;
            last_q <= instr_word;
        end
    end
endmodule // bbldec_progmem

// file: sim/tb.sv
`timescale 1ns/100ps
module tb;
    import bbldec_pkg::*;
    logic           clk = 1'b0;
    logic           reset_n = 1'b0;
    logic           test_true = 1'b0;
    logic           port_sel = 1'b1;
    logic           stall = 1'b0;
    logic [13:0]    instr_word, w_q;
    logic           instr_valid, dec_valid, no_op, cyc_end, rd_stb, wr_stb, pclr;
    logic           take_q = 1'b0;
    logic [1:0]     phase;
    logic [31:0]    got;
    logic [4:0]     ctl, cur_ctl = 5'h00;
    logic           cur_on = 1'b0, drop_q = 1'b0, busy_q = 1'b0, sel_q = 1'b0;
    bbldec_fields_t dec_fields;
    int             fail_count = 0;
    int             comparisons = 0;
    // Port clear, goto, bit test, literal with don't-care bits set, call
    logic [13:0]    corner [5] = '{14'h0185, 14'h2fff, 14'h1fff, 14'h33a5, 14'h2000};
    // 50 ns clock
    always #25 clk = ~clk;
    bbldec_decoder u_dut (.clk(clk), .reset_n(reset_n), .instr_word(instr_word), .instr_valid(instr_valid),
        .test_true(test_true), .port_one_register_sel(port_sel), .dec_valid(dec_valid), .dec_fields(dec_fields),
        .phase(phase), .file_rd_stb(rd_stb), .file_wr_stb(wr_stb), .no_operation_cycle(no_op),
        .cycle_end(cyc_end), .port_clear_read(pclr));
    bbldec_progmem u_mem (.clk(clk), .reset_n(reset_n), .phase(phase), .no_operation_cycle(no_op),
        .stall(stall), .drop(drop_q), .instr_word(instr_word), .instr_valid(instr_valid));
    assign got = {dec_fields.cls, dec_fields.file_addr, dec_fields.dest_file, dec_fields.bit_sel,
                  dec_fields.lit8, dec_fields.lit11};
    assign ctl = {dec_fields.file_read, dec_fields.file_write, dec_fields.clear_reg, dec_fields.pc_change,
                  dec_fields.cond_test};
    ////////////////////
    // Fields from the word layout; d only means something for byte ops
    function automatic logic [31:0] exp_f(input logic [13:0] w);
        logic [6:0] fa;
        logic       d;
        fa = w[6:0];
        d  = w[7];
        if (w[13:12] == 2'b01)
            d = 1'b1;
        else if (w[13:12] == 2'b11 || (w[13:8] == 6'h00 && !w[7]))
            d = 1'b0;
        else if (w[13:8] == 6'h01 && !w[7])
            fa = 7'h00;
        return {w[13:12], fa, d, w[9:7], w[7:0], w[10:0]};
    endfunction
    // Control bits {read, write, clear, counter change, test}
    function automatic logic [4:0] exp_ctl(input logic [13:0] w);
        logic [3:0] op;
        op = w[11:8];
        case (w[13:12])
            2'b00: begin
                if (op == 4'h0 && !w[7])
                    return {3'b000, w[6:0] == 7'h08 || w[6:0] == 7'h09, 1'b0};
                else if (op == 4'h1 && !w[7])
                    return 5'h00;
                else
                    return {1'b1, w[7], op == 4'h1, 1'b0, op == 4'hb || op == 4'hf};
            end
            2'b01: return {1'b1, !w[11], 2'b00, w[11]};
            2'b10: return 5'h02;
            default: return {3'b000, w[11:10] == 2'b01, 1'b0};
        endcase
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            fail_count++;
            $display("[ERR] %0t mismatch %h vs %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Step until memory reaches a word count; bounded
    task automatic run(input int upto, input bit rnd);
        for (int i = 0; i < 3000 && u_mem.idx < upto; i++) begin
            @(posedge clk);
            #2;
            if (rnd) begin
                test_true = 1'($urandom);
                port_sel = 1'($urandom);
                stall = $urandom_range(3, 0) == 0;
            end
        end
        if (u_mem.idx < upto) begin
            fail_count++;
            $display("[ERR] %0t words stuck", $time);
            report_and_stop();
        end else begin
            $display("words up to %0d done", upto);
        end
    endtask
    ////////////////////
    // Monitor on the falling edge, where all is settled
    always @(negedge clk) begin
        if (take_q) begin
            chk({31'h0, dec_valid}, 32'h1);
            chk(got, exp_f(w_q));
            chk({27'h0, ctl}, {27'h0, exp_ctl(w_q)});
            if (w_q[13:7] == 7'h03)
                chk({31'h0, dec_fields.clear_reg & dec_fields.file_read}, 32'h1);
        end
        // Cycle end and idle cycle follow from the cycle before
        if (reset_n && phase == 2'h0) begin
            chk({31'h0, cyc_end}, {31'h0, busy_q});
            chk({31'h0, no_op}, {31'h0, drop_q});
            sel_q = port_sel;
        end
        if (reset_n && phase == 2'h1) begin
            chk({31'h0, rd_stb}, {31'h0, cur_on & cur_ctl[4]});
            chk({31'h0, pclr}, {31'h0, cur_on & cur_ctl[2] & sel_q});
        end
        take_q = 1'b0;
        // A branch or true test drops the word offered at this phase 3
        if (reset_n && phase == 2'h3) begin
            chk({31'h0, wr_stb}, {31'h0, cur_on & cur_ctl[3]});
            drop_q = cur_on && (cur_ctl[1] || (cur_ctl[0] && test_true));
            busy_q = cur_on || no_op;
            take_q = instr_valid && !no_op && !drop_q;
            cur_on = take_q;
            cur_ctl = exp_ctl(instr_word);
        end
        w_q = instr_word;
    end
    // Main sequence
    initial begin
        void'($urandom(32'hd807bd1c));
        // corner word 3 has its don't-care bits set
        for (int i = 0; i < 64; i++)
            u_mem.mem[i] = i < 5 ? corner[i] : 14'($urandom);
        repeat (10) @(posedge clk);
        #2;
        reset_n = 1'b1;
        test_true = 1'b1;
        run(5, 1'b0);
        run(64, 1'b1);
        repeat (12) @(posedge clk);
        report_and_stop();
    end
endmodule // tb
bind bbldec_decoder bbldec_properties u_props (.clk(clk), .reset_n(reset_n), .instr_word(instr_word),
    .dec_valid(dec_valid), .dec_fields(dec_fields), .phase(phase), .file_rd_stb(file_rd_stb),
    .file_wr_stb(file_wr_stb), .no_operation_cycle(no_operation_cycle), .cycle_end(cycle_end),
    .port_clear_read(port_clear_read));
